// ### dwa_averager.sv
// Operation
// - Measure and zero starts selectable independently.
// - Mixed threshold and trigger start allowed.
// - Enable level matching start level permits running.
// - Max, min, peak-peak, mean over window.
// - Offset is zero-window mean, loaded at end.
// - Net value equals input minus offset.
// - Restart begins with a zero measurement.
// - Digital trigger selected ignores the threshold.
// - Digital start only on rising edge.
// - Constant trigger gives no edge, so no start; threshold ignored.
// - Enable flag change resets phase, timer, window, offset, results and ready; net value is kept.
// - Zero delay elapses before zero accumulation, except after reset or an enable change.
// - Results update together when ready rises.
// - Ready asserts when measuring window ends.
// - Status code shows the active phase.
// - Status codes 1, 3, 4, 5, 6, 7.
// - Measurement delay before window opens.
// - Zero window length disables measurement.
// - Threshold drop in window aborts to zero delay.
`timescale 1ns/1ps
`include "dwa_defs.svh"

module dwa_averager #(
    parameter int MS_CYCLES = `DWA_MS_CYCLES,
    parameter int CNT_W = `DWA_CNT_W
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // Sample stream and threshold
    input wire dwa_pkg::sample_t sample_in,
    input wire logic signed [`DWA_DATA_W-1:0] threshold_in,
    // Trigger and enable pins
    input wire logic enable_source_flag_in,
    input wire logic meas_trig_in,
    input wire logic zero_trig_in,
    // Configuration
    input wire logic start_level_in,
    input wire logic meas_trig_sel_in,
    input wire logic zero_trig_sel_in,
    input wire logic [`DWA_MS_W-1:0] meas_delay_ms_in,
    input wire logic [`DWA_MS_W-1:0] meas_time_ms_in,
    input wire logic [`DWA_MS_W-1:0] zero_delay_ms_in,
    input wire logic [`DWA_MS_W-1:0] zero_time_ms_in,
    // Results
    output logic signed [`DWA_DATA_W-1:0] net_out,
    output dwa_pkg::result_t results_out,
    output logic signed [`DWA_DATA_W-1:0] offset_out,
    output logic ready_out,
    output logic [2:0] status_out
);
    import dwa_pkg::*;

    localparam int W = `DWA_DATA_W;
    localparam int SW = W + CNT_W;
    localparam int PW = $clog2(MS_CYCLES);

    if (MS_CYCLES < 2 || CNT_W < 8 || CNT_W > 40) begin : g_bad
        $error("dwa_averager: unsupported parameters");
    end

    state_t state_r, state_nxt;
    logic [2:0] sync1_r, sync2_r, prev_r;
    logic [PW-1:0] presc_r;
    logic [`DWA_MS_W-1:0] ms_r;
    logic signed [SW-1:0] sum_r;
    logic [CNT_W-1:0] cnt_r;
    logic signed [W-1:0] max_r, min_r, offset_r, net_r;
    result_t res_r;
    logic ready_r;

    // Pins pass two flops; bit 0 enable, bit 1 measure, bit 2 zero.
    // No reset here: the chain settles to the pin levels while reset is
    // held for three clocks, so no false edge follows reset.
    always_ff @(posedge clk_sys_in) begin
        sync1_r <= {zero_trig_in, meas_trig_in, enable_source_flag_in};
        sync2_r <= sync1_r;
        prev_r <= sync2_r;
    end

    logic en_change, run_ok, meas_edge, zero_edge, thr_m, thr_z;
    logic signed [W:0] diff;
    logic signed [W-1:0] net_now, acc_val;
    logic above, below, meas_go, zero_go, ms_tick, tmr_clr;
    logic acc_en, div_go, div_done, cnt_nz;
    logic signed [SW-1:0] quot;

    assign en_change = sync2_r[0] ^ prev_r[0];
    assign run_ok = sync2_r[0] == start_level_in;
    assign meas_edge = sync2_r[1] & ~prev_r[1];
    assign zero_edge = sync2_r[2] & ~prev_r[2];
    assign thr_m = !meas_trig_sel_in;
    assign thr_z = !zero_trig_sel_in;
    assign diff = {sample_in.data[W-1], sample_in.data}
                - {offset_r[W-1], offset_r};
    assign net_now = diff[W-1:0];
    assign above = sample_in.valid && (net_now > threshold_in);
    assign below = sample_in.valid && (net_now < threshold_in);
    // Each start picks its own source; mixing is allowed.
    assign meas_go = run_ok && (meas_trig_sel_in ? meas_edge : above);
    assign zero_go = run_ok && (zero_trig_sel_in ? zero_edge : below);
    assign ms_tick = presc_r == PW'(MS_CYCLES - 1);
    assign tmr_clr = (state_nxt != state_r) || en_change;
    assign acc_en = sample_in.valid && !tmr_clr
                 && (state_r == ST_MEAS || state_r == ST_ZERO);
    assign acc_val = (state_r == ST_ZERO) ? sample_in.data : net_now;
    assign div_go = tmr_clr && !en_change
                 && (state_nxt == ST_MDIV || state_nxt == ST_ZDIV);
    assign cnt_nz = cnt_r != '0;
    assign status_out = state_r[2:0];

    always_comb begin
        state_nxt = state_r;
        if (en_change) begin
            state_nxt = ST_ZERO;
        end else begin
            unique case (state_r)
                ST_WAIT_MEAS: begin
                    if (meas_go) begin
                        state_nxt = (meas_time_ms_in == '0) ? ST_WAIT_ZERO
                                                            : ST_MDLY;
                    end
                end
                ST_MDLY: begin
                    if (thr_m && below) begin
                        state_nxt = ST_WAIT_MEAS;
                    end else if (ms_r >= meas_delay_ms_in) begin
                        state_nxt = ST_MEAS;
                    end
                end
                ST_MEAS: begin
                    if (thr_m && below) begin
                        state_nxt = ST_ZDLY;
                    end else if (ms_r >= meas_time_ms_in) begin
                        state_nxt = ST_MDIV;
                    end
                end
                ST_MDIV: begin
                    if (div_done) begin
                        state_nxt = ST_WAIT_ZERO;
                    end
                end
                ST_WAIT_ZERO: begin
                    if (zero_go) begin
                        state_nxt = (zero_time_ms_in == '0) ? ST_WAIT_MEAS
                                                            : ST_ZDLY;
                    end
                end
                ST_ZDLY: begin
                    if (thr_z && above) begin
                        state_nxt = ST_WAIT_MEAS;
                    end else if (ms_r >= zero_delay_ms_in) begin
                        state_nxt = ST_ZERO;
                    end
                end
                ST_ZERO: begin
                    if (thr_z && above) begin
                        state_nxt = ST_WAIT_MEAS;
                    end else if (ms_r >= zero_time_ms_in) begin
                        state_nxt = ST_ZDIV;
                    end
                end
                ST_ZDIV: begin
                    if (div_done) begin
                        state_nxt = ST_WAIT_MEAS;
                    end
                end
                default: state_nxt = ST_ZERO;
            endcase
        end
    end

    // Phase timer counts whole milliseconds since the phase began.
    always_ff @(posedge clk_sys_in) begin
        if (rst_in || tmr_clr) begin
            presc_r <= '0;
            ms_r <= '0;
        end else begin
            presc_r <= ms_tick ? '0 : presc_r + PW'(1);
            if (ms_tick && ms_r != '1) begin
                ms_r <= ms_r + `DWA_MS_W'(1);
            end
        end
    end

    // Running sum, count and extremes of the open window.
    always_ff @(posedge clk_sys_in) begin
        if (rst_in || (tmr_clr && (state_nxt == ST_MEAS
                                   || state_nxt == ST_ZERO))) begin
            sum_r <= '0;
            cnt_r <= '0;
            max_r <= {1'b1, {(W-1){1'b0}}};
            min_r <= {1'b0, {(W-1){1'b1}}};
        end else if (acc_en) begin
            sum_r <= sum_r + SW'(acc_val);
            cnt_r <= cnt_r + CNT_W'(1);
            if (acc_val > max_r) max_r <= acc_val;
            if (acc_val < min_r) min_r <= acc_val;
        end
    end

    dwa_divider #(.SW(SW), .CW(CNT_W)) u_div (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .start_in(div_go),
        .dividend_in(sum_r),
        .divisor_in(cnt_r),
        .done_out(div_done),
        .quotient_out(quot)
    );

    always_ff @(posedge clk_sys_in) begin
        if (rst_in || en_change) begin
            state_r <= ST_ZERO;
            offset_r <= '0;
            res_r <= '0;
            ready_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            if (state_r == ST_ZDIV && div_done && cnt_nz) begin
                offset_r <= quot[W-1:0];
            end
            if (state_r == ST_MDIV && div_done) begin
                ready_r <= 1'b1;
                if (cnt_nz) begin
                    res_r <= '{quot[W-1:0], max_r, min_r,
                               W'(max_r - min_r)};
                end
            end else if (tmr_clr && state_nxt == ST_MDLY) begin
                ready_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            net_r <= '0;
        end else if (sample_in.valid) begin
            net_r <= net_now;
        end
    end

    assign net_out = net_r;
    assign results_out = res_r;
    assign offset_out = offset_r;
    assign ready_out = ready_r;

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);

    a_net_follows: assert property (sample_in.valid |=>
        net_out == $past(net_now)) else $error("net value not refreshed");
    a_results_hold: assert property (!$rose(ready_r)
        && !$past(en_change) |-> $stable(res_r))
        else $error("results changed without ready");
    a_ready_end: assert property ($rose(ready_r) |->
        $past(state_r) == ST_MDIV) else $error("ready outside window end");
    a_trig_edge: assert property (state_r == ST_WAIT_MEAS
        && meas_trig_sel_in && !meas_edge && !en_change
        |=> state_r == ST_WAIT_MEAS) else $error("start without edge");
    a_toggle_reset: assert property (en_change |=>
        state_r == ST_ZERO && offset_r == '0 && !ready_r)
        else $error("enable change did not reset");
    a_zero_delay: assert property ($rose(state_r == ST_ZERO)
        && !$past(en_change) |-> $past(ms_r) >= $past(zero_delay_ms_in))
        else $error("zeroing began before delay");
    a_meas_delay: assert property ($rose(state_r == ST_MEAS) |->
        $past(ms_r) >= $past(meas_delay_ms_in))
        else $error("window opened before delay");
    a_meas_off: assert property (state_r == ST_WAIT_MEAS
        && meas_time_ms_in == '0 |=> state_r != ST_MDLY)
        else $error("measurement ran with zero window");
    a_thr_abort: assert property (state_r == ST_MEAS && thr_m
        && below && !en_change |=> state_r == ST_ZDLY)
        else $error("threshold drop did not abort");
    a_offset_load: assert property ($changed(offset_r)
        && !$past(en_change) |-> $past(state_r) == ST_ZDIV)
        else $error("offset loaded outside zero end");

    c_ready: cover property ($rose(ready_r));
    c_offset: cover property ($changed(offset_r) && !$past(en_change));
    c_abort: cover property (state_r == ST_MEAS ##1 state_r == ST_ZDLY);
    c_trig_meas: cover property (meas_trig_sel_in && meas_edge
        && state_r == ST_WAIT_MEAS ##1 state_r == ST_MDLY);

endmodule

// ### dwa_defs.svh
`ifndef DWA_DEFS_SVH
`define DWA_DEFS_SVH

`define DWA_DATA_W 24
`define DWA_MS_W 15
`define DWA_CNT_W 24
`define DWA_TICK_NS 1000000
`define DWA_CLK_NS 8
`define DWA_MS_CYCLES (`DWA_TICK_NS / `DWA_CLK_NS)
`define DWA_MAX_DELAY_MS 30000
`define DWA_MAX_TIME_MS 10000

`endif

// ### dwa_divider.sv
`timescale 1ns/1ps

module dwa_divider #(
    parameter int SW = 48,
    parameter int CW = 24
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // Request
    input wire logic start_in,
    input wire logic signed [SW-1:0] dividend_in,
    input wire logic [CW-1:0] divisor_in,
    // Answer
    output logic done_out,
    output logic signed [SW-1:0] quotient_out
);

    localparam int NW = $clog2(SW + 1);

    if (SW < 2 || CW < 1 || CW >= SW) begin : g_bad
        $error("dwa_divider: unsupported widths");
    end

    logic neg_r;
    logic busy_r;
    logic done_r;
    logic [NW-1:0] cnt_r;
    logic [CW:0] rem_r;
    logic [CW-1:0] div_r;
    logic [SW-1:0] quo_r;
    logic signed [SW-1:0] q_out_r;
    logic [SW-1:0] mag;
    logic [CW:0] rem_sh;
    logic [CW:0] diff;
    logic fits;
    logic last;

    assign mag = dividend_in[SW-1] ? SW'(-dividend_in) : dividend_in;
    assign rem_sh = {rem_r[CW-1:0], quo_r[SW-1]};
    assign diff = rem_sh - {1'b0, div_r};
    assign fits = !diff[CW];
    assign last = busy_r && (cnt_r == NW'(SW - 1));

    // Restoring division of the magnitude, one quotient bit per cycle.
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            busy_r <= 1'b0;
            done_r <= 1'b0;
            neg_r <= 1'b0;
            cnt_r <= '0;
            rem_r <= '0;
            div_r <= '0;
            quo_r <= '0;
            q_out_r <= '0;
        end else if (start_in) begin
            busy_r <= 1'b1;
            done_r <= 1'b0;
            neg_r <= dividend_in[SW-1];
            cnt_r <= '0;
            rem_r <= '0;
            div_r <= divisor_in;
            quo_r <= mag;
        end else if (busy_r) begin
            cnt_r <= cnt_r + NW'(1);
            rem_r <= fits ? diff : rem_sh;
            quo_r <= {quo_r[SW-2:0], fits};
            busy_r <= !last;
            done_r <= last;
            if (last) begin
                q_out_r <= neg_r ? SW'(-{quo_r[SW-2:0], fits})
                                 : {quo_r[SW-2:0], fits};
            end
        end else begin
            done_r <= 1'b0;
        end
    end

    assign done_out = done_r;
    assign quotient_out = q_out_r;

endmodule

// ### dwa_pkg.sv
`include "dwa_defs.svh"

package dwa_pkg;

    typedef struct packed {
        logic valid;
        logic signed [`DWA_DATA_W-1:0] data;
    } sample_t;

    typedef struct packed {
        logic signed [`DWA_DATA_W-1:0] mean;
        logic signed [`DWA_DATA_W-1:0] max;
        logic signed [`DWA_DATA_W-1:0] min;
        logic signed [`DWA_DATA_W-1:0] pp;
    } result_t;

    // The low three bits of each code are the reported section code.
    typedef enum logic [3:0] {
        ST_WAIT_MEAS = 4'h1,
        ST_MDLY = 4'h3,
        ST_MEAS = 4'h4,
        ST_MDIV = 4'hC,
        ST_WAIT_ZERO = 4'h5,
        ST_ZDLY = 4'h6,
        ST_ZERO = 4'h7,
        ST_ZDIV = 4'hF
    } state_t;

endpackage

// ### sample_source.sv
`timescale 1ns/1ps
`include "dwa_defs.svh"

module sample_source
    import dwa_pkg::*;
(
    // Clock
    input wire logic clk_sys_in,
    // Sample stream and trigger pins
    output dwa_pkg::sample_t sample_out,
    output logic meas_trig_out,
    output logic zero_trig_out
);
    initial begin
        sample_out = '0;
        meas_trig_out = 1'b0;
        zero_trig_out = 1'b0;
    end

    // Outside a strobe the data is inverted so a stale value never matches.
    task automatic send(input logic signed [`DWA_DATA_W-1:0] d);
        @(negedge clk_sys_in);
        sample_out.valid = 1'b1;
        sample_out.data = d;
        @(negedge clk_sys_in);
        sample_out.valid = 1'b0;
        sample_out.data = ~d;
    endtask

    task automatic set_trig(input logic m, input logic z);
        @(negedge clk_sys_in);
        meas_trig_out = m;
        zero_trig_out = z;
    endtask
endmodule

// ### testbench.sv
`timescale 1ns/1ps
`include "dwa_defs.svh"

module testbench;
    import dwa_pkg::*;
    localparam int MS = 10;
    logic clk_sys_in;
    logic rst_in;
    sample_t sample;
    logic meas_trig;
    logic zero_trig;
    logic enable_flag;
    logic meas_sel;
    logic zero_sel;
    logic signed [`DWA_DATA_W-1:0] threshold;
    logic [`DWA_MS_W-1:0] meas_time;
    logic start_level;
    logic [`DWA_MS_W-1:0] meas_delay;
    logic [`DWA_MS_W-1:0] zero_delay;
    logic [`DWA_MS_W-1:0] zero_time;
    logic signed [`DWA_DATA_W-1:0] net;
    logic signed [`DWA_DATA_W-1:0] offset;
    result_t results;
    logic ready;
    logic [2:0] status;
    logic signed [`DWA_DATA_W-1:0] win [4];
    int fail_count = 0;
    int checks_done = 0;

    sample_source src (
        .clk_sys_in(clk_sys_in),
        .sample_out(sample),
        .meas_trig_out(meas_trig),
        .zero_trig_out(zero_trig)
    );

    dwa_averager #(.MS_CYCLES(MS)) dut (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .sample_in(sample),
        .threshold_in(threshold),
        .enable_source_flag_in(enable_flag),
        .meas_trig_in(meas_trig),
        .zero_trig_in(zero_trig),
        .start_level_in(start_level),
        .meas_trig_sel_in(meas_sel),
        .zero_trig_sel_in(zero_sel),
        .meas_delay_ms_in(meas_delay),
        .meas_time_ms_in(meas_time),
        .zero_delay_ms_in(zero_delay),
        .zero_time_ms_in(zero_time),
        .net_out(net),
        .results_out(results),
        .offset_out(offset),
        .ready_out(ready),
        .status_out(status)
    );

    initial begin
        clk_sys_in = 1'b0;
        forever #4 clk_sys_in = ~clk_sys_in;
    end

    task automatic final_report;
        $display("checks %0d, failures %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic check_val(input string what, input logic [23:0] exp,
                             input logic [23:0] got);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wait_status(input logic [2:0] s);
        int n;
        n = 0;
        while (status !== s && n < 600) begin
            @(negedge clk_sys_in);
            n++;
        end
        check_val("status wait", {21'h0, s}, {21'h0, status});
        if (status !== s) begin
            final_report();
        end
    endtask

    initial begin
        rst_in = 1'b1;
        enable_flag = 1'b1;
        meas_sel = 1'b1;
        zero_sel = 1'b1;
        threshold = 24'h7F_FFFF;
        meas_time = 15'h0002;
        start_level = 1'b1;
        meas_delay = 15'h0001;
        zero_delay = 15'h0001;
        zero_time = 15'h0001;
        win = '{24'h00_0096, 24'h00_006E, 24'h00_0082, 24'h00_006E};
        repeat (12) @(negedge clk_sys_in);
        check_val("reset status", 24'h00_0007, {21'h0, status});
        check_val("reset offset", 24'h00_0000, offset);
        rst_in = 1'b0;
        repeat (3) src.send(24'h00_0064);
        wait_status(3'h1);
        check_val("offset first", 24'h00_0064, offset);
        src.send(24'h00_0082);
        check_val("net", 24'h00_001E, net);
        // Digital starts with an unreachable threshold.
        src.set_trig(1'b1, 1'b0);
        wait_status(3'h3);
        wait_status(3'h4);
        check_val("mean held", 24'h00_0000, results.mean);
        for (int i = 0; i < 4; i++) begin
            src.send(win[i]);
        end
        wait_status(3'h5);
        check_val("ready", 24'h00_0001, {23'h0, ready});
        check_val("mean", 24'h00_0019, results.mean);
        check_val("max", 24'h00_0032, results.max);
        check_val("min", 24'h00_000A, results.min);
        check_val("pp", 24'h00_0028, results.pp);
        src.set_trig(1'b1, 1'b1);
        wait_status(3'h6);
        check_val("offset kept", 24'h00_0064, offset);
        wait_status(3'h7);
        src.send(24'h00_00C8);
        src.send(24'h00_00D2);
        wait_status(3'h1);
        check_val("offset zero", 24'h00_00CD, offset);
        repeat (30) @(negedge clk_sys_in);
        check_val("level no start", 24'h00_0001, {21'h0, status});
        src.set_trig(1'b0, 1'b0);
        // Threshold measurement start mixed with a digital zeroing start.
        meas_sel = 1'b0;
        threshold = 24'h00_0014;
        src.send(24'h00_00D2);
        repeat (3) @(negedge clk_sys_in);
        check_val("below thr", 24'h00_0001, {21'h0, status});
        for (int i = 0; i < 20 && status !== 3'h4; i++) begin
            src.send(24'h00_00FA);
        end
        check_val("thr start", 24'h00_0004, {21'h0, status});
        src.send(24'h00_00D2);
        repeat (2) @(negedge clk_sys_in);
        check_val("abort", 24'h00_0006, {21'h0, status});
        check_val("abort ready", 24'h00_0000, {23'h0, ready});
        check_val("abort mean", 24'h00_0019, results.mean);
        wait_status(3'h1);
        check_val("empty zero", 24'h00_00CD, offset);
        enable_flag = 1'b0;
        repeat (5) @(negedge clk_sys_in);
        check_val("en status", 24'h00_0007, {21'h0, status});
        check_val("en offset", 24'h00_0000, offset);
        check_val("en mean", 24'h00_0000, results.mean);
        // Enable is low now, so a high start level refuses every start.
        wait_status(3'h1);
        meas_time = 15'h0000;
        src.send(24'h00_00FA);
        repeat (3) @(negedge clk_sys_in);
        check_val("run off", 24'h00_0001, {21'h0, status});
        start_level = 1'b0;
        src.send(24'h00_00FA);
        repeat (2) @(negedge clk_sys_in);
        check_val("no window", 24'h00_0005, {21'h0, status});
        check_val("no ready", 24'h00_0000, {23'h0, ready});
        // Threshold zeroing, skipped by a value above the threshold.
        zero_sel = 1'b0;
        zero_delay = 15'h0002;
        src.send(24'h00_0000);
        wait_status(3'h6);
        src.send(24'h00_00FA);
        repeat (2) @(negedge clk_sys_in);
        check_val("zero skip", 24'h00_0001, {21'h0, status});
        check_val("zero kept", 24'h00_0000, offset);
        final_report();
    end
endmodule
